// >>> rtl/blank_chop_pkg.sv
// Package for the PWM blanking, chopping and time base capture block.
// Assumes a 50 MHz clk and an APB slave with one 32-bit word per register.
package blank_chop_pkg;
  localparam logic [11:0] ADDR_LEB_CTRL = 12'h000;
  localparam logic [11:0] ADDR_DELAY = 12'h004;
  localparam logic [11:0] ADDR_AUX = 12'h008;
  localparam logic [11:0] ADDR_CAPTURE = 12'h00c;
  localparam logic [11:0] ADDR_CORE_CTRL = 12'h010;
  localparam logic [15:0] LEB_CTRL_MASK = 16'hfc3f;
  localparam logic [15:0] DELAY_MASK = 16'h0ff8;
  localparam logic [15:0] AUX_MASK = 16'hcf3f;
  localparam logic [15:0] CAPTURE_MASK = 16'hfff8;
  localparam logic [15:0] CORE_CTRL_MASK = 16'h0002;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  localparam int BIT_RISE_PRI = 15;
  localparam int BIT_FALL_PRI = 14;
  localparam int BIT_RISE_SEC = 13;
  localparam int BIT_FALL_SEC = 12;
  localparam int BIT_FLT_LEB_EN = 11;
  localparam int BIT_CL_LEB_EN = 10;
  localparam int BIT_SRC_HIGH = 5;
  localparam int BIT_SRC_LOW = 4;
  localparam int BIT_PRI_HIGH = 3;
  localparam int BIT_PRI_LOW = 2;
  localparam int BIT_SEC_HIGH = 1;
  localparam int BIT_SEC_LOW = 0;
  localparam int DELAY_LSB = 3;
  localparam int DELAY_W = 9;
  localparam int BIT_HIRES_PERIOD_OFF = 15;
  localparam int BIT_HIRES_DUTY_OFF = 14;
  localparam int BLANK_SRC_LSB = 8;
  localparam int CHOP_SRC_LSB = 2;
  localparam int SEL_W = 4;
  localparam int BIT_CHOP_HIGH = 1;
  localparam int BIT_CHOP_LOW = 0;
  localparam int CAPTURE_LSB = 3;
  localparam int CAPTURE_W = 13;
  localparam int BIT_EXT_PERIOD_RESET = 1;
  localparam int NUM_GEN = 5;
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_LAST_GEN = 4'h5;
  localparam int CLK_PERIOD_PS = 20000;
  localparam int BLANK_STEP_PS = 8320;
  // Blanking delays are set in 8.32 ns steps; the counter adds this many picoseconds per clock
  localparam logic [15:0] STEPS_PER_CLK = 16'(CLK_PERIOD_PS);
  localparam logic [15:0] STEP_PS = 16'(BLANK_STEP_PS);
  typedef struct packed {
    logic primary_output;
    logic secondary_output;
  } pwm_pair_s;
endpackage : blank_chop_pkg

// >>> rtl/pwm_blanking_chop_capture.sv
// PWM generator auxiliary logic: state and leading-edge blanking, chopping, capture.
// Assumes all inputs synchronous to clk and APB software access.
// Operation
// R1: Blank inputs while secondary output high
// R2: Blank inputs while secondary output low
// R3: Nine-bit delay field, 8.32 ns counts
// R4: Bit 15 disables high-resolution period
// R5: Bit 14 disables high-resolution duty
// R6: State blank source: none or generator
// R7: Source blanks only per high/low enables
// R8: Chop source: internal clock or generator
// R9: Chop signal gates enabled outputs
// R10: Chop primary output when enabled
// R11: Chop secondary output when enabled
// R12: Current-limit leading edge captures time base
// R13: Capture applies to primary time base
// R14: Capture only after blanking completes
// R15: Capture resolution 8.32 ns per count
// R16: Software keeps external period reset clear
// R17: Unimplemented bits read as zero
// R18: Enabled edges restart blanking counter
// R19: Masked inputs gated by any blanking
module pwm_blanking_chop_capture
  import blank_chop_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire blank_chop_pkg::pwm_pair_s pwm_in,
  input wire logic [blank_chop_pkg::NUM_GEN-1:0] gen_primary_outputs,
  input wire logic chop_clock,
  input wire logic [blank_chop_pkg::CAPTURE_W-1:0] primary_timebase,
  input wire logic fault_raw,
  input wire logic current_limit_raw,
  output blank_chop_pkg::pwm_pair_s pwm_out,
  output logic fault_masked,
  output logic current_limit_masked,
  output logic hires_period_off,
  output logic hires_duty_off,
  output logic external_period_reset
);
  import blank_chop_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [15:0] leb_ctrl;
  logic [15:0] delay_reg;
  logic [15:0] aux_ctrl;
  logic [15:0] core_ctrl;
  logic [CAPTURE_W-1:0] capture_value;
  logic wr_en;
  logic addr_ok;
  logic pri_q;
  logic sec_q;
  logic cl_q;
  logic blank_active;
  logic [DELAY_W+16:0] blank_acc;
  logic [DELAY_W+16:0] blank_limit;
  logic edge_hit;
  logic state_blank;
  logic src_sig;
  logic chop_sig;
  logic leb_blank_flt;
  logic leb_blank_cl;
  logic next_flt;
  logic next_cl;
  logic [3:0] blank_sel;
  logic [3:0] chop_sel;
  logic [DELAY_W-1:0] blank_delay_count;

  assign addr_ok = (paddr == ADDR_LEB_CTRL) || (paddr == ADDR_DELAY) || (paddr == ADDR_AUX)
    || (paddr == ADDR_CAPTURE) || (paddr == ADDR_CORE_CTRL);
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addr_ok;
  assign blank_sel = aux_ctrl[BLANK_SRC_LSB +: SEL_W];
  assign chop_sel = aux_ctrl[CHOP_SRC_LSB +: SEL_W];
  assign blank_delay_count = delay_reg[DELAY_LSB +: DELAY_W];

  // R17 masks keep unimplemented bits at zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      leb_ctrl <= RESET_VALUE;
      delay_reg <= RESET_VALUE;
      aux_ctrl <= RESET_VALUE;
      core_ctrl <= RESET_VALUE;
    end else if (wr_en) begin
      unique case (paddr)
        ADDR_LEB_CTRL: leb_ctrl <= pwdata[15:0] & LEB_CTRL_MASK;
        // R3 delay field storage
        ADDR_DELAY: delay_reg <= pwdata[15:0] & DELAY_MASK;
        ADDR_AUX: aux_ctrl <= pwdata[15:0] & AUX_MASK;
        ADDR_CORE_CTRL: core_ctrl <= pwdata[15:0] & CORE_CTRL_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ADDR_LEB_CTRL: prdata <= {16'h0000, leb_ctrl};
        ADDR_DELAY: prdata <= {16'h0000, delay_reg};
        ADDR_AUX: prdata <= {16'h0000, aux_ctrl};
        // R17 low capture bits read zero
        ADDR_CAPTURE: prdata <= {16'h0000, capture_value, 3'h0};
        ADDR_CORE_CTRL: prdata <= {16'h0000, core_ctrl};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // R4 R5 power-saving disables
  assign hires_period_off = aux_ctrl[BIT_HIRES_PERIOD_OFF];
  assign hires_duty_off = aux_ctrl[BIT_HIRES_DUTY_OFF];
  // R16 software keeps this clear while capturing
  assign external_period_reset = core_ctrl[BIT_EXT_PERIOD_RESET];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pri_q <= 1'b0;
      sec_q <= 1'b0;
      cl_q <= 1'b0;
    end else begin
      pri_q <= pwm_in.primary_output;
      sec_q <= pwm_in.secondary_output;
      cl_q <= current_limit_raw;
    end
  end

  assign edge_hit = (leb_ctrl[BIT_RISE_PRI] && pwm_in.primary_output && !pri_q)
    || (leb_ctrl[BIT_FALL_PRI] && !pwm_in.primary_output && pri_q)
    || (leb_ctrl[BIT_RISE_SEC] && pwm_in.secondary_output && !sec_q)
    || (leb_ctrl[BIT_FALL_SEC] && !pwm_in.secondary_output && sec_q);
  // Compare elapsed picoseconds so 8.32 ns steps need no fractional divider
  assign blank_limit = (DELAY_W+17)'(blank_delay_count) * (DELAY_W+17)'(STEP_PS);

  // R18 edge restarts the blanking counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blank_active <= 1'b0;
      blank_acc <= '0;
    end else if (edge_hit && blank_delay_count != '0) begin
      blank_active <= 1'b1;
      blank_acc <= (DELAY_W+17)'(STEPS_PER_CLK);
    end else if (blank_active) begin
      blank_acc <= blank_acc + (DELAY_W+17)'(STEPS_PER_CLK);
      if (blank_acc >= blank_limit) begin
        blank_active <= 1'b0;
      end
    end
  end

  assign leb_blank_flt = blank_active && leb_ctrl[BIT_FLT_LEB_EN];
  assign leb_blank_cl = blank_active && leb_ctrl[BIT_CL_LEB_EN];

  // R6 state blank source select
  always_comb begin
    src_sig = 1'b0;
    if (blank_sel != SEL_NONE && blank_sel <= SEL_LAST_GEN) begin
      src_sig = gen_primary_outputs[3'(blank_sel - 4'h1)];
    end
  end

  // R1 R2 R7 state blanking conditions
  assign state_blank = (leb_ctrl[BIT_SEC_HIGH] && pwm_in.secondary_output)
    || (leb_ctrl[BIT_SEC_LOW] && !pwm_in.secondary_output)
    || (leb_ctrl[BIT_PRI_HIGH] && pwm_in.primary_output)
    || (leb_ctrl[BIT_PRI_LOW] && !pwm_in.primary_output)
    || (blank_sel != SEL_NONE && blank_sel <= SEL_LAST_GEN
        && ((leb_ctrl[BIT_SRC_HIGH] && src_sig) || (leb_ctrl[BIT_SRC_LOW] && !src_sig)));

  // R19 gate raw inputs off during blanking
  assign next_flt = fault_raw && !state_blank && !leb_blank_flt;
  assign next_cl = current_limit_raw && !state_blank && !leb_blank_cl;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_masked <= 1'b0;
      current_limit_masked <= 1'b0;
    end else begin
      fault_masked <= next_flt;
      current_limit_masked <= next_cl;
    end
  end

  // R12 R13 R14 R15 capture primary time base after blanking
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      capture_value <= '0;
    end else if (next_cl && !current_limit_masked && (current_limit_raw && !cl_q
                 || !leb_blank_cl)) begin
      capture_value <= primary_timebase;
    end
  end

  // R8 chop source select
  always_comb begin
    chop_sig = chop_clock;
    if (chop_sel != SEL_NONE) begin
      chop_sig = 1'b0;
      if (chop_sel <= SEL_LAST_GEN) begin
        chop_sig = gen_primary_outputs[3'(chop_sel - 4'h1)];
      end
    end
  end

  // R9 R10 R11 chop gating of enabled outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwm_out <= '0;
    end else begin
      pwm_out.primary_output <= pwm_in.primary_output && (!aux_ctrl[BIT_CHOP_HIGH] || chop_sig);
      pwm_out.secondary_output <= pwm_in.secondary_output
        && (!aux_ctrl[BIT_CHOP_LOW] || chop_sig);
    end
  end

  // Software write to the auxiliary register
  sequence s_aux_write;
    psel && penable && pwrite && paddr == ADDR_AUX;
  endsequence

  // Enabled output edge with a nonzero delay
  sequence s_blank_start;
    edge_hit && blank_delay_count != '0;
  endsequence

  // Masked current limit about to rise
  sequence s_cl_rise;
    next_cl && !current_limit_masked;
  endsequence

  // Setup cycle of a capture register read
  sequence s_capture_read;
    psel && !penable && !pwrite && paddr == ADDR_CAPTURE;
  endsequence

  // R17 unimplemented bits stay zero
  a_reserved_zero: assert property ( // R17
    (delay_reg & ~DELAY_MASK) == 16'h0 && (aux_ctrl & ~AUX_MASK) == 16'h0)
    else $error("reserved bits set");

  // R1 secondary high blanks current limit
  a_sec_high_blank: assert property ( // R1
    leb_ctrl[BIT_SEC_HIGH] && pwm_in.secondary_output |=> !current_limit_masked)
    else $error("secondary high not blanked");

  // R1 secondary high blanks fault
  a_sec_high_fault: assert property ( // R1
    leb_ctrl[BIT_SEC_HIGH] && pwm_in.secondary_output |=> !fault_masked)
    else $error("secondary high fault not blanked");

  // R2 secondary low blanks fault
  a_sec_low_blank: assert property ( // R2
    leb_ctrl[BIT_SEC_LOW] && !pwm_in.secondary_output |=> !fault_masked)
    else $error("secondary low not blanked");

  // R2 secondary low blanks current limit
  a_sec_low_cl: assert property ( // R2
    leb_ctrl[BIT_SEC_LOW] && !pwm_in.secondary_output |=> !current_limit_masked)
    else $error("secondary low limit not blanked");

  // R4 period disable takes written bit
  a_hires_period: assert property ( // R4
    s_aux_write |=> hires_period_off == $past(pwdata[BIT_HIRES_PERIOD_OFF]))
    else $error("period disable wrong");

  // R5 duty disable takes written bit
  a_hires_duty: assert property ( // R5
    s_aux_write |=> hires_duty_off == $past(pwdata[BIT_HIRES_DUTY_OFF]))
    else $error("duty disable wrong");

  // R19 unblanked fault passes through
  a_fault_pass: assert property ( // R19
    !state_blank && !blank_active |=> fault_masked == $past(fault_raw))
    else $error("fault not passed");

  // R19 unblanked current limit passes
  a_cl_pass: assert property ( // R19
    !state_blank && !blank_active |=> current_limit_masked == $past(current_limit_raw))
    else $error("current limit not passed");

  // R19 masked fault needs raw fault
  a_fault_needs_raw: assert property ( // R19
    fault_masked |-> $past(fault_raw))
    else $error("fault invented");

  // R10 chop low kills primary output
  a_chop_primary: assert property ( // R10
    aux_ctrl[BIT_CHOP_HIGH] && !chop_sig |=> !pwm_out.primary_output)
    else $error("primary not chopped");

  // R10 unchopped primary passes
  a_primary_pass: assert property ( // R10
    !aux_ctrl[BIT_CHOP_HIGH] |=> pwm_out.primary_output == $past(pwm_in.primary_output))
    else $error("primary wrongly chopped");

  // R11 unchopped secondary passes
  a_chop_secondary: assert property ( // R11
    !aux_ctrl[BIT_CHOP_LOW] |=> pwm_out.secondary_output == $past(pwm_in.secondary_output))
    else $error("secondary wrongly chopped");

  // R11 chop low kills secondary
  a_chop_sec_gate: assert property ( // R11
    aux_ctrl[BIT_CHOP_LOW] && !chop_sig |=> !pwm_out.secondary_output)
    else $error("secondary not chopped");

  // R8 code zero picks chop clock
  a_chop_internal: assert property ( // R8
    chop_sel == SEL_NONE |-> chop_sig == chop_clock)
    else $error("chop clock not selected");

  // R8 reserved chop codes idle
  a_chop_reserved: assert property ( // R8
    chop_sel > SEL_LAST_GEN |-> !chop_sig)
    else $error("reserved chop source active");

  // R6 code zero means no source
  a_blank_src_none: assert property ( // R6
    blank_sel == SEL_NONE |-> !src_sig)
    else $error("state blank source without select");

  // R7 high source blanks when allowed
  a_state_src_high: assert property ( // R7
    blank_sel != SEL_NONE && blank_sel <= SEL_LAST_GEN && leb_ctrl[BIT_SRC_HIGH] && src_sig
    |=> !current_limit_masked && !fault_masked)
    else $error("source high not blanked");

  // R7 low source blanks when allowed
  a_state_src_low: assert property ( // R7
    blank_sel != SEL_NONE && blank_sel <= SEL_LAST_GEN && leb_ctrl[BIT_SRC_LOW] && !src_sig
    |=> !current_limit_masked && !fault_masked)
    else $error("source low not blanked");

  // R18 enabled edge starts blanking
  a_blank_start: assert property ( // R18
    s_blank_start |=> blank_active)
    else $error("blanking not started");

  // R18 blanking ends within bound
  a_blank_ends: assert property ( // R18
    $rose(blank_active) |-> ##[1:250] !blank_active)
    else $error("blanking stuck");

  // R18 blanking masks current limit
  a_leb_masks_cl: assert property ( // R18
    leb_blank_cl |=> !current_limit_masked)
    else $error("current limit not blanked");

  // R18 blanking masks fault
  a_leb_masks_flt: assert property ( // R18
    leb_blank_flt |=> !fault_masked)
    else $error("fault not blanked");

  // R14 no capture while blanked
  a_no_capture_blanked: assert property ( // R14
    leb_blank_cl || state_blank |=> $stable(capture_value))
    else $error("capture during blanking");

  // R12 rising limit captures time base
  a_capture_rise: assert property ( // R12
    s_cl_rise |=> capture_value == $past(primary_timebase))
    else $error("time base not captured");

  // R12 capture holds otherwise
  a_capture_hold: assert property ( // R12
    !(next_cl && !current_limit_masked) |=> $stable(capture_value))
    else $error("capture changed without edge");

  // R17 capture read pads with zeros
  a_capture_read_low: assert property ( // R17
    s_capture_read |=> prdata[2:0] == 3'h0 && prdata[31:16] == 16'h0)
    else $error("capture read padding wrong");
endmodule : pwm_blanking_chop_capture

// >>> dv/pwm_core_model.sv
// Far-side model: PWM core pins, peer generators, chop clock and time base.
// Assumes the bench asks for levels; they reach the pins one clock later.
module pwm_core_model
  import blank_chop_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire blank_chop_pkg::pwm_pair_s want_pair,
  input wire logic [blank_chop_pkg::NUM_GEN-1:0] want_gen,
  input wire logic want_chop,
  input wire logic [blank_chop_pkg::CAPTURE_W-1:0] want_time,
  output blank_chop_pkg::pwm_pair_s pwm_in,
  output logic [blank_chop_pkg::NUM_GEN-1:0] gen_primary_outputs,
  output logic chop_clock,
  output logic [blank_chop_pkg::CAPTURE_W-1:0] primary_timebase
);
  timeunit 1ns;
  timeprecision 1ps;
  // Registered, so every pin moves just after an edge as a real core does
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwm_in <= 2'h0;
      gen_primary_outputs <= 5'h00;
      chop_clock <= 1'b0;
      primary_timebase <= 13'h0000;
    end else begin
      pwm_in <= want_pair;
      gen_primary_outputs <= want_gen;
      chop_clock <= want_chop;
      primary_timebase <= want_time;
    end
  end
endmodule : pwm_core_model

// >>> dv/tb_pwm_blanking_chop_capture.sv
// Self-checking bench for the blanking, chop and capture block.
// Assumes the far-side model in pwm_core_model and an APB master here.
module tb_pwm_blanking_chop_capture;
  timeunit 1ns;
  timeprecision 1ps;
  import blank_chop_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, chop_clock, fault_masked, current_limit_masked;
  logic hires_period_off, hires_duty_off, external_period_reset;
  pwm_pair_s want_pair = 2'h0;
  pwm_pair_s pwm_in, pwm_out;
  logic [4:0] want_gen = 5'h00;
  logic [4:0] gen_primary_outputs, g;
  logic want_chop = 1'b0;
  logic fault_raw = 1'b0;
  logic current_limit_raw = 1'b0;
  logic [12:0] want_time = 13'h0000;
  logic [12:0] primary_timebase, t;
  logic blk, c;
  int n_fail = 0;
  int tests_run = 0;
  int seed = 32'h11c49166;
  logic [31:0] expq[$];
  logic [31:0] r;
  logic [11:0] addrs [5] = '{ADDR_LEB_CTRL, ADDR_DELAY, ADDR_AUX, ADDR_CAPTURE, 12'h014};
  logic [15:0] masks [5] = '{LEB_CTRL_MASK, DELAY_MASK, AUX_MASK, 16'h0000, 16'h0000};

  always #10 clk = ~clk;

  pwm_core_model far (.clk, .sys_rst, .want_pair, .want_gen, .want_chop, .want_time,
    .pwm_in, .gen_primary_outputs, .chop_clock, .primary_timebase);
  pwm_blanking_chop_capture dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pwm_in, .gen_primary_outputs, .chop_clock,
    .primary_timebase, .fault_raw, .current_limit_raw, .pwm_out, .fault_masked,
    .current_limit_masked, .hires_period_off, .hires_duty_off, .external_period_reset);

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task stop_test;
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  // Holds the request until pready is seen high at an edge
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask : rd

  task masked_is(input logic exp);
    repeat (3) @(posedge clk);
    check({fault_masked, current_limit_masked}, {2{exp}});
  endtask : masked_is

  // Read data is judged at the access edge; unmapped places must refuse
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expq.size() == 0) n_fail++;
      else check(prdata, expq.pop_front());
      check(pslverr, paddr > ADDR_CORE_CTRL);
    end
  end

  initial begin
    #200us;
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    foreach (addrs[i]) rd(addrs[i], 32'h0);
    for (int i = 0; i < 5; i++) begin
      r = $random(seed);
      apb(addrs[i], 1'b1, r);
      rd(addrs[i], {16'h0, r[15:0] & masks[i]});
    end
    for (int i = 1; i < 4; i++) begin
      apb(ADDR_AUX, 1'b1, {16'h0, i[1:0], 14'h0});
      check(hires_period_off, i[1]);
      check(hires_duty_off, i[0]);
    end
    apb(ADDR_CORE_CTRL, 1'b1, 32'h0);
    check(external_period_reset, 1'b0);
    apb(ADDR_DELAY, 1'b1, 32'h0);
    apb(ADDR_AUX, 1'b1, 32'h0);
    fault_raw <= 1'b1;
    current_limit_raw <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i[0] == 1'b0) apb(ADDR_LEB_CTRL, 1'b1, {30'h0, i[2:1]});
      want_pair <= {1'b0, i[0]};
      masked_is(!(i[0] ? i[2] : i[1]));
    end
    apb(ADDR_LEB_CTRL, 1'b1, 32'h0);
    for (int s = 0; s < 10; s++) begin
      g = $random(seed);
      apb(ADDR_LEB_CTRL, 1'b1, s[0] ? 32'h20 : 32'h10);
      apb(ADDR_AUX, 1'b1, {20'h0, s[3:0], 8'h0});
      want_gen <= g;
      blk = (s >= 1 && s <= 5) && (g[s-1] == s[0]);
      masked_is(!blk);
    end
    want_pair <= 2'h3;
    for (int s = 0; s < 10; s++) begin
      g = $random(seed);
      c = $random(seed);
      apb(ADDR_AUX, 1'b1, {26'h0, s[3:0], 2'(s % 3 + 1)});
      want_gen <= g;
      want_chop <= c;
      repeat (3) @(posedge clk);
      blk = (s == 0) ? c : (s <= 5) ? g[s-1] : 1'b0;
      check(pwm_out, {(s % 3 == 0) || blk, (s % 3 == 1) || blk});
    end
    apb(ADDR_AUX, 1'b1, 32'h0);
    apb(ADDR_LEB_CTRL, 1'b1, 32'h8400);
    apb(ADDR_DELAY, 1'b1, {20'h0, 9'h018, 3'h0});
    t = $random(seed);
    current_limit_raw <= 1'b0;
    want_pair <= 2'h0;
    want_time <= t;
    repeat (3) @(posedge clk);
    want_pair <= 2'h2;
    // The pin reaches the block a cycle late; raise the limit once blanking runs
    repeat (2) @(posedge clk);
    current_limit_raw <= 1'b1;
    repeat (4) @(posedge clk);
    check(current_limit_masked, 1'b0);
    current_limit_raw <= 1'b0;
    repeat (20) @(posedge clk);
    rd(ADDR_CAPTURE, 32'h0);
    current_limit_raw <= 1'b1;
    masked_is(1'b1);
    rd(ADDR_CAPTURE, {16'h0, t, 3'h0});
    stop_test();
  end
endmodule : tb_pwm_blanking_chop_capture
